/* verilog/scsi_intr_seq.sv */
// Behaviour
// RQ1 - Cause read clears cause, step, interrupt
// RQ2 - Bus reset sets bit 7 if reporting
// RQ3 - Illegal command code sets bit 6
// RQ4 - Disconnect or selection timeout sets bit 5
// RQ5 - ATN or phase request sets bit 4
// RQ6 - Function complete sets bit 3
// RQ7 - Reselected bit 2, selected bits 1/0
// RQ8 - Software reads step before cause
// RQ9 - Write-only selection timeout register
// RQ10 - Step register: substep, offset-limit bit
// RQ11 - Select-with-ATN-and-stop outcome codes
// RQ12 - Select-without-ATN outcome codes
// RQ13 - Select-with-ATN outcome codes
// RQ14 - Three-message-byte select outcome codes
// RQ15 - Target selected without ATN codes
// RQ16 - Target selected with ATN codes
// RQ17 - Target receive-command outcome codes
// RQ18 - Target disconnect outcome codes
// RQ19 - Terminate and command-complete outcome codes
// RQ20 - Period register sets REQ/ACK spacing
// RQ21 - Period code to clock mapping
// RQ22 - Offset register limits outstanding REQ/ACK
// RQ23 - Unreported bus reset goes idle quietly
// RQ24 - Status interrupt flag cleared by read
// RQ25 - Interrupt output held until cause read
`timescale 1ns/1ps
`include "scsi_intr_map.svh"

module scsi_intr_seq
  import scsi_intr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic RD,
  input wire logic WR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic RESET_REPORT_OFF,
  input wire logic SCSI_RESET_SEEN,
  input wire logic ILLEGAL_CMD,
  input wire logic DISCONNECTED,
  input wire logic BUS_SERVICE,
  input wire logic FUNC_DONE,
  input wire logic RESELECTED,
  input wire logic SEQ_END,
  input wire logic [3:0] SEQ_KIND,
  input wire logic [2:0] SEQ_OUTCOME,
  input wire logic SEQ_ATN,
  input wire logic SEL_START,
  input wire logic SEL_ANSWER,
  input wire logic TX_WANT,
  input wire logic ACK_SEEN,
  input wire logic FIFO_POP,
  output logic INT_REQ,
  output logic STATUS_INT,
  output logic GO_IDLE,
  output logic SEL_TIMEOUT,
  output logic TX_STROBE,
  output logic RX_ACK
);

  logic rst_meta_q;
  logic rst_sync_q;
  ctl_s st_q;
  ctl_s st_d;
  logic limit_hit;
  logic rd_cause;
  logic [7:0] set_bits;
  logic [10:0] report;
  logic [8:0] ticks;
  logic bus_reset_quiet;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Sequence outcome to {step, cause}; unknown kinds report nothing
  function automatic logic [10:0] seq_report(logic [3:0] kind, logic [2:0] outc, logic atn);
    logic [2:0] s;
    logic [7:0] c;
    logic [7:0] atn_bit;
    s = `STEP_0;
    c = `CAUSE_NONE;
    atn_bit = atn ? `CAUSE_ATN_SEEN : `CAUSE_NONE;
    unique case (kind)
      K_SEL_ATN_STOP, K_SEL_NOATN, K_SEL_ATN, K_SEL_SELECT_THREE_MESSAGE_BYTES:
      begin
        c = (outc == O_TIMEOUT) ? `CAUSE_SEL_TIMEOUT : `CAUSE_STOPPED; // [RQ11] [RQ12]
        unique case (outc)
          O_TIMEOUT: s = `STEP_0; // [RQ11] [RQ12]
          // Without ATN there is no message phase, so an early stop is step 2
          O_EARLY: s = (kind == K_SEL_NOATN) ? `STEP_2 : `STEP_0; // [RQ11] [RQ12]
          // Stop variant holds ATN after one byte; others stop after message-out
          O_MID: s = (kind == K_SEL_ATN_STOP) ? `STEP_1 : `STEP_2; // [RQ11] [RQ13] [RQ14]
          O_NO_CMD: s = `STEP_2; // [RQ12] [RQ13] [RQ14]
          O_CMD_SHORT: s = `STEP_3; // [RQ12] [RQ13] [RQ14]
          O_DONE: s = (kind == K_SEL_ATN_STOP) ? `STEP_1 : `STEP_4; // [RQ11] [RQ12] [RQ13]
          default:
          begin
            s = `STEP_0;
            c = `CAUSE_NONE;
          end
        endcase
      end
      K_TGT_SEL_NOATN, K_TGT_SEL_ATN:
      begin
        c = ((kind == K_TGT_SEL_ATN) ? `CAUSE_TGT_SEL_ATN : `CAUSE_TGT_SEL) | atn_bit; // [RQ15] [RQ16]
        unique case (outc)
          O_EARLY: s = `STEP_0; // [RQ15] [RQ16]
          O_MID: s = `STEP_1; // [RQ15] [RQ16]
          default: s = `STEP_2; // [RQ15] [RQ16]
        endcase
      end
      K_TGT_RCV_CMD:
      begin
        c = `CAUSE_TGT_CMD | atn_bit; // [RQ17]
        s = (outc == O_DONE) ? `STEP_2 : `STEP_1; // [RQ17]
      end
      K_TGT_DISC, K_TGT_TERM, K_TGT_CMD_CMPL:
      begin
        unique case (outc)
          O_EARLY:
          begin
            s = `STEP_0;
            c = `CAUSE_STOPPED; // [RQ18] [RQ19]
          end
          O_DONE:
          begin
            s = `STEP_2;
            c = `CAUSE_DISC_DONE; // [RQ18] [RQ19]
          end
          default:
          begin
            s = `STEP_1;
            c = `CAUSE_STOPPED; // [RQ18] [RQ19]
          end
        endcase
      end
      default:
      begin
        s = `STEP_0;
        c = `CAUSE_NONE;
      end
    endcase
    return {s, c};
  endfunction : seq_report

  // Register file, event capture and selection timer
  always_comb
  begin
    st_d = st_q;
    st_d.tmo = 1'b0;
    st_d.idle = 1'b0;
    set_bits = `CAUSE_NONE;
    report = seq_report(SEQ_KIND, SEQ_OUTCOME, SEQ_ATN);
    rd_cause = RD && (ADDR == `REG_CAUSE_RD);
    bus_reset_quiet = SCSI_RESET_SEEN && RESET_REPORT_OFF;
    ticks = (st_q.timeout == 8'h00) ? `SEL_ZERO_TICKS : {1'b0, st_q.timeout};

    // Read data is latched one cycle after the strobe; unmapped reads give zero
    if (RD)
    begin
      if (ADDR == `REG_CAUSE_RD)
        st_d.rdata = st_q.cause;
      else if (ADDR == `REG_STEP_RD)
        st_d.rdata = {4'h0, limit_hit, st_q.step}; // [RQ10]
      else
        st_d.rdata = 8'h00;
    end

    // Software reads step first, because this read wipes it [RQ8]
    if (rd_cause && st_q.sint)
    begin
      st_d.cause = `CAUSE_NONE; // [RQ1]
      st_d.step = `STEP_0; // [RQ1]
      st_d.sint = 1'b0; // [RQ24]
      st_d.irq = 1'b0; // [RQ1]
    end

    // Timeout and period writes share indices with the cause and step reads; offset has its own
    if (WR)
    begin
      if (ADDR == `REG_TIMEOUT_WR)
        st_d.timeout = WDATA; // [RQ9]
      else if (ADDR == `REG_PERIOD_WR)
        st_d.period = WDATA[4:0]; // [RQ20]
      else if (ADDR == `REG_OFFSET_WR)
        st_d.offset = WDATA[3:0]; // [RQ22]
    end

    // Selection wait; a quiet bus reset kills it so no timeout follows
    unique case (st_q.tstate)
      T_IDLE:
      begin
        if (SEL_START && !bus_reset_quiet)
        begin
          st_d.tstate = T_RUN;
          st_d.tcnt = 12'(ticks) * 12'(`SEL_TICK_CYC); // [RQ9]
        end
      end
      T_RUN:
      begin
        if (SEL_ANSWER || SCSI_RESET_SEEN)
          st_d.tstate = T_IDLE; // [RQ23]
        else if (st_q.tcnt <= 12'h001)
        begin
          st_d.tstate = T_IDLE;
          st_d.tmo = 1'b1; // [RQ9]
        end
        else
          st_d.tcnt = st_q.tcnt - 12'h001;
      end
      default: st_d.tstate = T_IDLE;
    endcase

    // Quiet reset disconnects and idles without any cause bit
    if (bus_reset_quiet)
      st_d.idle = 1'b1; // [RQ23]
    if (SCSI_RESET_SEEN && !RESET_REPORT_OFF)
      set_bits[`CAUSE_BUS_RESET_BIT] = 1'b1; // [RQ2]
    if (ILLEGAL_CMD)
      set_bits[`CAUSE_ILLEGAL_BIT] = 1'b1; // [RQ3]
    if (DISCONNECTED)
      set_bits[`CAUSE_DISCONNECT_BIT] = 1'b1; // [RQ4]
    if (BUS_SERVICE)
      set_bits[`CAUSE_SERVICE_BIT] = 1'b1; // [RQ5]
    if (FUNC_DONE)
      set_bits[`CAUSE_FUNC_DONE_BIT] = 1'b1; // [RQ6]
    if (RESELECTED)
      set_bits[`CAUSE_RESELECTED_BIT] = 1'b1; // [RQ7]
    if (st_q.tmo)
    begin
      set_bits = set_bits | `CAUSE_SEL_TIMEOUT; // [RQ4] [RQ11]
      st_d.step = `STEP_0; // [RQ12]
    end
    if (SEQ_END)
    begin
      set_bits = set_bits | report[7:0]; // [RQ7] [RQ15] [RQ16]
      st_d.step = report[10:8]; // [RQ10]
    end

    // New events win over a clearing read in the same cycle
    if (set_bits != `CAUSE_NONE)
    begin
      st_d.cause = st_d.cause | set_bits;
      st_d.sint = 1'b1;
      st_d.irq = 1'b1; // [RQ25]
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      st_q <= '0;
      st_q.period <= `PERIOD_RST; // [RQ20]
      st_q.timeout <= `TIMEOUT_RST;
      st_q.offset <= `OFFSET_RST;
      st_q.tstate <= T_IDLE;
    end
    else
      st_q <= st_d;
  end

  // REQ/ACK spacing and offset tracking
  sync_pacer u_pacer (
    .clk(CORE_CLK),
    .rst_n(rst_sync_q),
    .period_code(st_q.period),
    .offset_lim(st_q.offset),
    .tx_want(TX_WANT),
    .ack_seen(ACK_SEEN),
    .fifo_pop(FIFO_POP),
    .tx_strobe(TX_STROBE),
    .rx_ack(RX_ACK),
    .limit_hit(limit_hit)
  );

  assign RDATA = st_q.rdata;
  assign INT_REQ = st_q.irq;
  assign STATUS_INT = st_q.sint;
  assign GO_IDLE = st_q.idle;
  assign SEL_TIMEOUT = st_q.tmo;

endmodule : scsi_intr_seq

/* verilog/scsi_intr_map.svh */
`ifndef SCSI_INTR_MAP_SVH
`define SCSI_INTR_MAP_SVH

// Register indices, taken from address bits 5:2
`define REG_CAUSE_RD 4'h5
`define REG_TIMEOUT_WR 4'h5
`define REG_STEP_RD 4'h6
`define REG_PERIOD_WR 4'h6
`define REG_OFFSET_WR 4'h7

// Interrupt cause bit positions
`define CAUSE_BUS_RESET_BIT 7
`define CAUSE_ILLEGAL_BIT 6
`define CAUSE_DISCONNECT_BIT 5
`define CAUSE_SERVICE_BIT 4
`define CAUSE_FUNC_DONE_BIT 3
`define CAUSE_RESELECTED_BIT 2
`define CAUSE_SEL_ATN_BIT 1
`define CAUSE_SELECTED_BIT 0

// Composite cause codes reported by sequences
`define CAUSE_NONE 8'h00
`define CAUSE_SEL_TIMEOUT 8'h20
`define CAUSE_STOPPED 8'h18
`define CAUSE_DISC_DONE 8'h28
`define CAUSE_TGT_SEL 8'h01
`define CAUSE_TGT_SEL_ATN 8'h02
`define CAUSE_TGT_CMD 8'h08
`define CAUSE_ATN_SEEN 8'h10

// Sequence step codes
`define STEP_0 3'h0
`define STEP_1 3'h1
`define STEP_2 3'h2
`define STEP_3 3'h3
`define STEP_4 3'h4

// Reset values
`define PERIOD_RST 5'h05
`define TIMEOUT_RST 8'h00
`define OFFSET_RST 4'h0

// Period code mapping
`define PERIOD_LOW_CODES 5'h04
`define PERIOD_WRAP_BASE 6'h20
`define PERIOD_MIN 6'h05

// Selection timeout unit and clock
`define CLK_PERIOD_NS 100
`define SEL_TICK_NS 800
`define SEL_TICK_CYC ((`SEL_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEL_ZERO_TICKS 9'h100

`endif

/* verilog/scsi_intr_pkg.sv */
package scsi_intr_pkg;

  typedef enum logic [3:0] {
    K_SEL_ATN_STOP = 4'h0,
    K_SEL_NOATN = 4'h1,
    K_SEL_ATN = 4'h2,
    K_SEL_SELECT_THREE_MESSAGE_BYTES = 4'h3,
    K_TGT_SEL_NOATN = 4'h4,
    K_TGT_SEL_ATN = 4'h5,
    K_TGT_RCV_CMD = 4'h6,
    K_TGT_DISC = 4'h7,
    K_TGT_TERM = 4'h8,
    K_TGT_CMD_CMPL = 4'h9
  } seq_kind_e;

  typedef enum logic [2:0] {
    O_TIMEOUT = 3'h0,
    O_EARLY = 3'h1,
    O_MID = 3'h2,
    O_NO_CMD = 3'h3,
    O_CMD_SHORT = 3'h4,
    O_DONE = 3'h5
  } seq_outcome_e;

  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_RUN = 2'b10
  } sel_timer_e;

  typedef struct packed {
    logic [7:0] cause;
    logic [2:0] step;
    logic sint;
    logic irq;
    logic [7:0] timeout;
    logic [4:0] period;
    logic [3:0] offset;
    logic [7:0] rdata;
    logic idle;
    logic tmo;
    sel_timer_e tstate;
    logic [11:0] tcnt;
  } ctl_s;

  typedef struct packed {
    logic [5:0] gap;
    logic [4:0] outst;
    logic tx;
    logic rx_ack;
    logic hit;
  } pacer_s;

endpackage : scsi_intr_pkg

/* verilog/sync_pacer.sv */
`timescale 1ns/1ps
`include "scsi_intr_map.svh"

module sync_pacer
  import scsi_intr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] period_code,
  input wire logic [3:0] offset_lim,
  input wire logic tx_want,
  input wire logic ack_seen,
  input wire logic fifo_pop,
  output logic tx_strobe,
  output logic rx_ack,
  output logic limit_hit
);

  pacer_s p_q;
  pacer_s p_d;
  logic [5:0] spacing;
  logic [4:0] lim;
  logic go;

  // Code to clock periods: low four codes wrap above 31, 4 and 5 both give 5
  function automatic logic [5:0] period_cycles(logic [4:0] code);
    logic [5:0] r;
    r = {1'b0, code};
    if (code < `PERIOD_LOW_CODES)
      r = `PERIOD_WRAP_BASE + {1'b0, code}; // [RQ21]
    else if (code == `PERIOD_LOW_CODES)
      r = `PERIOD_MIN; // [RQ21]
    return r;
  endfunction : period_cycles

  // Pacing and offset bookkeeping
  always_comb
  begin
    p_d = p_q;
    p_d.tx = 1'b0;
    spacing = period_cycles(period_code);
    // Offset zero is interlocked: only one pulse may be outstanding
    lim = (offset_lim == 4'h0) ? 5'h01 : {1'b0, offset_lim}; // [RQ22]
    if (p_q.gap != 6'h00)
      p_d.gap = p_q.gap - 6'h01;
    go = tx_want && (p_q.gap == 6'h00) && (p_q.outst < lim); // [RQ20] [RQ22]
    if (go)
    begin
      p_d.tx = 1'b1;
      p_d.gap = spacing - 6'h01; // [RQ20]
    end
    // Each ACK received frees one slot for the next byte
    if (go && !(ack_seen && p_q.outst != 5'h00))
      p_d.outst = p_q.outst + 5'h01;
    else if (!go && ack_seen && p_q.outst != 5'h00)
      p_d.outst = p_q.outst - 5'h01; // [RQ22]
    p_d.hit = (offset_lim != 4'h0) && (p_d.outst >= lim); // [RQ10] [RQ22]
    p_d.rx_ack = fifo_pop && (offset_lim != 4'h0); // [RQ22]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      p_q <= '0;
    else
      p_q <= p_d;
  end

  assign tx_strobe = p_q.tx;
  assign rx_ack = p_q.rx_ack;
  assign limit_hit = p_q.hit;

endmodule : sync_pacer

/* verif/scsi_far_end.sv */
`timescale 1ns/1ps
// Bus peer: answers every REQ/ACK leading edge with one ACK LAG+1 cycles later
module scsi_far_end #(
  parameter int LAG = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe,
  output logic ack
);
  logic [3:0] cnt_q;
  // One ACK per strobe, so the block's interlock is never fed a spare one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 4'h0;
      ack <= 1'b0;
    end
    else
    begin
      cnt_q <= strobe ? 4'(LAG) : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      ack <= cnt_q == 4'h1;
    end
  end
endmodule : scsi_far_end

/* verif/scsi_intr_seq_asserts.sv */
`timescale 1ns/1ps
module scsi_intr_seq_chk (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic RD,
  input wire logic RESET_REPORT_OFF,
  input wire logic SCSI_RESET_SEEN,
  input wire logic ILLEGAL_CMD,
  input wire logic DISCONNECTED,
  input wire logic BUS_SERVICE,
  input wire logic FUNC_DONE,
  input wire logic RESELECTED,
  input wire logic SEQ_END,
  input wire logic INT_REQ,
  input wire logic STATUS_INT,
  input wire logic SEL_TIMEOUT,
  input wire logic TX_STROBE
);
  default clocking dc @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  logic tmo_q;
  // Expiry posts its cause one cycle late, so it still counts as an event then
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      tmo_q <= 1'b0;
    else
      tmo_q <= SEL_TIMEOUT;
  end
  // Anything that may set a cause bit now, and a cause read
  wire logic post = SCSI_RESET_SEEN && !RESET_REPORT_OFF || ILLEGAL_CMD || DISCONNECTED
    || BUS_SERVICE || FUNC_DONE || RESELECTED || SEQ_END || SEL_TIMEOUT || tmo_q;
  wire logic clr = RD && ADDR == 4'h5;
  chk_read_clears: assert property (clr && STATUS_INT && !post |=> !INT_REQ)
    else $error("interrupt stayed up after cause read");
  chk_reset_post: assert property (SCSI_RESET_SEEN && !RESET_REPORT_OFF |=> INT_REQ)
    else $error("reported bus reset raised no interrupt");
  chk_event_post: assert property (
    ILLEGAL_CMD || DISCONNECTED || BUS_SERVICE || RESELECTED |=> INT_REQ)
    else $error("event raised no interrupt");
  chk_done_post: assert property (FUNC_DONE || SEQ_END |=> INT_REQ)
    else $error("completion raised no interrupt");
  chk_quiet_reset: assert property (
    SCSI_RESET_SEEN && RESET_REPORT_OFF && !INT_REQ && !post |=> !INT_REQ)
    else $error("unreported bus reset raised an interrupt");
  chk_int_holds: assert property (INT_REQ && !clr |=> INT_REQ)
    else $error("interrupt dropped without cause read");
  chk_status_int: assert property (STATUS_INT == INT_REQ)
    else $error("status flag differs from interrupt");
  chk_tmo_post: assert property (SEL_TIMEOUT |-> ##[1:3] INT_REQ)
    else $error("selection timeout raised no interrupt");
  chk_strobe_gap: assert property (TX_STROBE |=> !TX_STROBE [*4])
    else $error("strobes closer than five cycles");
  cover property (clr && STATUS_INT);
  cover property (SEL_TIMEOUT);
  cover property (TX_STROBE ##[5:40] TX_STROBE);
endmodule : scsi_intr_seq_chk

bind scsi_intr_seq scsi_intr_seq_chk u_chk (.CORE_CLK, .RST_N, .ADDR, .RD, .RESET_REPORT_OFF,
  .SCSI_RESET_SEEN, .ILLEGAL_CMD, .DISCONNECTED, .BUS_SERVICE, .FUNC_DONE, .RESELECTED,
  .SEQ_END, .INT_REQ, .STATUS_INT, .SEL_TIMEOUT, .TX_STROBE);

/* verif/scsi_intr_seq_bench.sv */
`timescale 1ns/1ps
`include "scsi_intr_map.svh"
module scsi_intr_seq_bench;
  logic CORE_CLK = 1'b0, RST_N = 1'b0, RD = 1'b0, WR = 1'b0, SEQ_ATN = 1'b0;
  logic [3:0] ADDR = 4'h0, SEQ_KIND = 4'h0;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic [2:0] SEQ_OUTCOME = 3'h0;
  logic RESET_REPORT_OFF = 1'b0, SCSI_RESET_SEEN = 1'b0, ILLEGAL_CMD = 1'b0;
  logic DISCONNECTED = 1'b0, BUS_SERVICE = 1'b0, FUNC_DONE = 1'b0, RESELECTED = 1'b0;
  logic SEQ_END = 1'b0, SEL_START = 1'b0, SEL_ANSWER = 1'b0, TX_WANT = 1'b0, FIFO_POP = 1'b0;
  logic ACK_SEEN, INT_REQ, STATUS_INT, GO_IDLE, SEL_TIMEOUT, TX_STROBE, RX_ACK;
  int n_mismatch = 0, cmp_count = 0, b, t0, p, cyc;
  int hit[4], lst[4], prv[4];
  // kind, outcome, step, ATN, cause
  // Later rows reach an early or a mid stop for kinds 0 to 5, 7 and 8
  logic [23:0] tab [21] = '{24'h452001, 24'h552002, 24'h652118, 24'h154018, 24'h232018,
    24'h243018, 24'h752028, 24'h952028, 24'h852028, 24'h000020, 24'h051018, 24'h354018,
    24'h410001, 24'h521112, 24'h710018, 24'h821018, 24'h112018, 24'h021018, 24'h210018,
    24'h322018, 24'h641008};
  // Written code, expected spacing; reserved upper bits set in the first
  logic [15:0] per [4] = '{16'hE606, 16'h0020, 16'h0405, 16'h1F1F};
  wire logic [3:0] outs = {RX_ACK, TX_STROBE, SEL_TIMEOUT, GO_IDLE};

  always #50 CORE_CLK = ~CORE_CLK;

  scsi_intr_seq dut (.CORE_CLK, .RST_N, .ADDR, .RD, .WR, .WDATA, .RDATA, .RESET_REPORT_OFF,
    .SCSI_RESET_SEEN, .ILLEGAL_CMD, .DISCONNECTED, .BUS_SERVICE, .FUNC_DONE, .RESELECTED,
    .SEQ_END, .SEQ_KIND, .SEQ_OUTCOME, .SEQ_ATN, .SEL_START, .SEL_ANSWER, .TX_WANT, .ACK_SEEN,
    .FIFO_POP, .INT_REQ, .STATUS_INT, .GO_IDLE, .SEL_TIMEOUT, .TX_STROBE, .RX_ACK);
  scsi_far_end peer (.clk(CORE_CLK), .rst_n(RST_N), .strobe(TX_STROBE), .ack(ACK_SEEN));

  // Pulses are counted at the falling edge, where they are settled and never missed
  always @(negedge CORE_CLK)
  begin
    cyc++;
    for (int k = 0; k < 4; k++)
      if (outs[k] === 1'b1)
      begin
        prv[k] = lst[k];
        lst[k] = cyc;
        hit[k]++;
      end
  end

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(negedge CORE_CLK);
    ADDR = a;
    RD = 1'b1;
    @(negedge CORE_CLK);
    RD = 1'b0;
    @(negedge CORE_CLK);
    chk(what, RDATA, exp);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge CORE_CLK);
    ADDR = a;
    WDATA = d;
    WR = 1'b1;
    @(negedge CORE_CLK);
    WR = 1'b0;
  endtask : wr

  task automatic pulse(input int i);
    @(negedge CORE_CLK);
    case (i)
      7: SCSI_RESET_SEEN = 1'b1;
      6: ILLEGAL_CMD = 1'b1;
      5: DISCONNECTED = 1'b1;
      4: BUS_SERVICE = 1'b1;
      3: FUNC_DONE = 1'b1;
      2: RESELECTED = 1'b1;
      1: SEQ_END = 1'b1;
      0: SEL_START = 1'b1;
      9: SEL_ANSWER = 1'b1;
      default: FIFO_POP = 1'b1;
    endcase
    @(negedge CORE_CLK);
    {SCSI_RESET_SEEN, ILLEGAL_CMD, DISCONNECTED, BUS_SERVICE} = 4'h0;
    {FUNC_DONE, RESELECTED, SEQ_END, SEL_START, FIFO_POP, SEL_ANSWER} = 6'h00;
  endtask : pulse

  // Bounded wait for a new output pulse; running out ends the run
  task automatic wait_for(input int sel, input int base, input int lim);
    int n;
    n = 0;
    while (hit[sel] == base && n < lim)
    begin
      @(negedge CORE_CLK);
      #1;
      n++;
    end
    if (hit[sel] == base)
    begin
      n_mismatch++;
      $display("ERROR pulse %0d expected 1 seen 0", sel);
      close_out();
    end
  endtask : wait_for

  task automatic service(input logic [7:0] st, input logic [7:0] ca);
    @(negedge CORE_CLK);
    chk("irq", {7'h00, INT_REQ}, 8'h01);
    rd(`REG_STEP_RD, st, "step");
    rd(`REG_CAUSE_RD, ca, "cause");
    chk("irq clr", {7'h00, INT_REQ}, 8'h00);
    chk("stat clr", {7'h00, STATUS_INT}, 8'h00);
    rd(`REG_STEP_RD, 8'h00, "step clr");
  endtask : service

  initial
  begin
    repeat (6) @(negedge CORE_CLK);
    RST_N = 1'b1;
    repeat (3) @(negedge CORE_CLK);
    rd(`REG_CAUSE_RD, 8'h00, "cause rst");
    rd(4'h0, 8'h00, "unmapped");
    for (int i = 7; i >= 2; i--)
    begin
      pulse(i);
      service(8'h00, 8'h01 << i);
    end
    for (int i = 0; i < 21; i++)
    begin
      SEQ_KIND = tab[i][23:20];
      SEQ_OUTCOME = tab[i][18:16];
      SEQ_ATN = tab[i][8];
      pulse(1);
      service({4'h0, tab[i][15:12]}, tab[i][7:0]);
    end
    wr(`REG_TIMEOUT_WR, 8'h01);
    // A quiet bus reset must kill a running selection wait, as must an answer
    RESET_REPORT_OFF = 1'b1;
    b = hit[0];
    t0 = hit[1];
    pulse(0);
    pulse(7);
    wait_for(0, b, 4);
    pulse(0);
    pulse(9);
    repeat (20) @(negedge CORE_CLK);
    chk("no tmo", {7'h00, hit[1] == t0}, 8'h01);
    chk("quiet irq", {7'h00, INT_REQ}, 8'h00);
    rd(`REG_CAUSE_RD, 8'h00, "quiet cause");
    RESET_REPORT_OFF = 1'b0;
    b = hit[1];
    t0 = cyc;
    pulse(0);
    wait_for(1, b, 40);
    chk("tmo len", {7'h00, (lst[1] - t0) inside {[8:12]}}, 8'h01);
    repeat (2) @(negedge CORE_CLK);
    service(8'h00, 8'h20);
    TX_WANT = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(`REG_PERIOD_WR, per[i][15:8]);
      p = per[i][7:0];
      repeat (3)
      begin
        b = hit[2];
        wait_for(2, b, 100);
      end
      chk("gap", {7'h00, (lst[2] - prv[2]) inside {[p:p + 2]}}, 8'h01);
    end
    // Offset one: a strobe awaiting its ACK holds the limit bit of the step register
    wr(`REG_OFFSET_WR, 8'h01);
    b = hit[2];
    wait_for(2, b, 100);
    rd(`REG_STEP_RD, 8'h08, "limit bit");
    TX_WANT = 1'b0;
    wr(`REG_OFFSET_WR, 8'h02);
    b = hit[3];
    pulse(8);
    wait_for(3, b, 4);
    close_out();
  end
endmodule : scsi_intr_seq_bench
